//--- shared/uifmc_map.svh
// register offsets, field positions and reset values of the uart irq/flow/modem block
`ifndef UIFMC_MAP_SVH
`define UIFMC_MAP_SVH

// register byte offsets
`define UIFMC_OFF_FIFO_LEVEL 8'h00
`define UIFMC_OFF_FLOW_CTRL 8'h04
`define UIFMC_OFF_IRQ_ENABLE 8'h08
`define UIFMC_OFF_IRQ_RAW 8'h0C
`define UIFMC_OFF_IRQ_MASKED 8'h10
`define UIFMC_OFF_IRQ_CLEAR 8'h14
`define UIFMC_OFF_MODEM_SET 8'h18
`define UIFMC_OFF_MODEM_CLEAR 8'h1C
`define UIFMC_OFF_MODEM_STATUS 8'h20

// fifo level register fields
`define UIFMC_TX_SEL_LSB 0
`define UIFMC_RX_SEL_LSB 4

// flow control register fields
`define UIFMC_CTS_GATED_BIT 0
`define UIFMC_RTS_DRIVEN_BIT 1

// modem control fields
`define UIFMC_DTR_BIT 0
`define UIFMC_RTS_BIT 1

// interrupt source positions
`define UIFMC_IRQ_ADDR_MATCH 0
`define UIFMC_IRQ_OVERRUN 1
`define UIFMC_IRQ_BREAK 2
`define UIFMC_IRQ_PARITY 3
`define UIFMC_IRQ_FRAMING 4
`define UIFMC_IRQ_RX_TIMEOUT 5
`define UIFMC_IRQ_TRANSMIT 6
`define UIFMC_IRQ_RECEIVE 7
`define UIFMC_IRQ_DSR 8
`define UIFMC_IRQ_DCD 9
`define UIFMC_IRQ_CTS 10
`define UIFMC_IRQ_RI 11
`define UIFMC_IRQ_COUNT 12

// modem status input positions
`define UIFMC_MS_CTS 0
`define UIFMC_MS_DSR 1
`define UIFMC_MS_DCD 2
`define UIFMC_MS_RI 3

// reset values
`define UIFMC_RST_FIFO_SEL 3'h2
`define UIFMC_RST_IRQ_ENABLE 12'h000
`define UIFMC_RST_FLOW 2'h0
`define UIFMC_RST_MODEM 2'h0

`endif

//--- shared/uifmc_pkg.sv
// types shared by the uart irq/flow/modem block
package uifmc_pkg;

    // fifo fill threshold selection, in eighths of depth
    typedef enum logic [2:0] {
        THRESH_ONE_EIGHTH,
        THRESH_TWO_EIGHTHS,
        THRESH_FOUR_EIGHTHS,
        THRESH_SIX_EIGHTHS,
        THRESH_SEVEN_EIGHTHS
    } uifmc_thresh_type;

    // wishbone classic request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } uifmc_wb_req_type;

    // one-cycle event pulses from the receive datapath
    typedef struct packed {
        logic address_match;
        logic overrun;
        logic break_seen;
        logic parity_fault;
        logic framing_fault;
        logic receive_timeout;
    } uifmc_rx_event_type;

    // modem status lines, high means asserted
    typedef struct packed {
        logic ri;
        logic dcd;
        logic dsr;
        logic cts;
    } uifmc_modem_in_type;

endpackage

//--- hw/uifmc_sync.sv
// two-flop synchroniser for a group of asynchronous input pins
`timescale 1ns/10ps
module uifmc_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] D,
    output logic [WIDTH-1:0] Q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } uifmc_sync_state_type;

    uifmc_sync_state_type s_q;
    uifmc_sync_state_type s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d = s_q;
        s_d.meta = D;
        s_d.stable = s_q.meta;
    end

    // state register, frozen while CE is low
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q <= '0;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign Q = s_q.stable;

endmodule

//--- hw/uifmc_top.sv
// uart interrupt, hardware flow control and modem control block with wishbone registers
//
// Overview of operation
// RULE_01: tx and rx fifo thresholds each select one, two, four, six or seven eighths.
// RULE_02: with cts gating on, transmission is allowed only while cts is asserted.
// RULE_03: with rts driving on, rts asserts only while the receive fifo has room.
// RULE_04: transmit and receive flow enables are independent and read back.
// RULE_05: a per-source enable mask lets software permit sources bit by bit.
// RULE_06: only enabled sources reach the interrupt output.
// RULE_07: twelve sources: address, overrun, break, parity, framing, timeout, tx, rx, modem changes.
// RULE_08: software clears selected sources by mask until their condition recurs.
// RULE_09: both raw and masked interrupt status can be read.
// RULE_10: software deasserts dtr and rts individually by bit mask.
// RULE_11: software asserts dtr and rts individually; unselected outputs stay unchanged.
// RULE_12: present dtr and rts states read back, set meaning asserted.
// RULE_13: interrupt output is the or of masked status, one cycle after changes.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "uifmc_map.svh"
module uifmc_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int LEVEL_W = 5
) (
    // clock, reset and clock enable
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // wishbone classic slave
    input wire uifmc_pkg::uifmc_wb_req_type WB_REQ,
    output logic WB_ACK,
    output logic [31:0] WB_DAT,
    // fifo fill levels from the datapath, same clock
    input wire logic [LEVEL_W-1:0] TX_FIFO_LEVEL,
    input wire logic [LEVEL_W-1:0] RX_FIFO_LEVEL,
    // receive events from the datapath, same clock
    input wire uifmc_pkg::uifmc_rx_event_type RX_EVENTS,
    // modem status pins, asynchronous
    input wire uifmc_pkg::uifmc_modem_in_type MODEM_IN,
    // transmit permission to the serializer
    output logic TX_SEND_OK,
    // modem control pins, high means asserted
    output logic RTS,
    output logic DTR,
    // interrupt to the processor
    output logic IRQ
);

    typedef struct packed {
        uifmc_pkg::uifmc_thresh_type tx_sel;
        uifmc_pkg::uifmc_thresh_type rx_sel;
        logic cts_gated_transmit_enable;
        logic rts_driven_receive_enable;
        logic [`UIFMC_IRQ_COUNT-1:0] irq_en;
        logic [`UIFMC_IRQ_COUNT-1:0] irq_raw;
        logic dtr_sw;
        logic rts_sw;
        logic [3:0] modem_prev;
        logic tx_cond;
        logic rx_cond;
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic rts_pin;
        logic dtr_pin;
        logic send_ok;
    } uifmc_state_type;

    uifmc_state_type s_q;
    uifmc_state_type s_d;
    logic [3:0] modem_sync;

    // modem pins cross into the clock domain before any use
    uifmc_sync #(
        .WIDTH(4)
    ) u_modem_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .CE(CE),
        .D(MODEM_IN),
        .Q(modem_sync)
    );

    // level in entries that an eighths selection stands for
    function automatic logic [LEVEL_W-1:0] thresh_level(input uifmc_pkg::uifmc_thresh_type sel);
        int n;
        n = 1;
        case (sel)
            uifmc_pkg::THRESH_ONE_EIGHTH: n = 1;
            uifmc_pkg::THRESH_TWO_EIGHTHS: n = 2;
            uifmc_pkg::THRESH_FOUR_EIGHTHS: n = 4;
            uifmc_pkg::THRESH_SIX_EIGHTHS: n = 6;
            uifmc_pkg::THRESH_SEVEN_EIGHTHS: n = 7;
            default: n = 1;
        endcase
        return LEVEL_W'((FIFO_DEPTH * n) / 8);
    endfunction

    // only the five legal codes are stored; others keep the old choice
    function automatic uifmc_pkg::uifmc_thresh_type legal_sel(input logic [2:0] code,
                                                              input uifmc_pkg::uifmc_thresh_type old);
        uifmc_pkg::uifmc_thresh_type r;
        r = old;
        if (code <= 3'h4) begin
            r = uifmc_pkg::uifmc_thresh_type'(code);
        end
        return r;
    endfunction

    // byte lanes present on the bus
    logic [31:0] lane_mask;
    logic [31:0] wval;
    logic wr_go;
    logic rd_go;
    logic [`UIFMC_IRQ_COUNT-1:0] irq_set;
    logic [`UIFMC_IRQ_COUNT-1:0] irq_clr;
    logic [3:0] modem_edge;
    logic tx_cond_now;
    logic rx_cond_now;
    logic rx_has_room;

    // byte lane expansion, one generate per lane
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign lane_mask[g*8 +: 8] = {8{WB_REQ.sel[g]}};
        end
    endgenerate

    // register map, byte offsets on the bus:
    //   00 fifo level, rw: tx selection in 2:0, rx selection in 6:4
    //   04 flow control, rw: bit 0 cts gating, bit 1 rts driving
    //   08 interrupt enable, rw, merged per byte lane
    //   0c raw interrupt status, ro
    //   10 masked interrupt status, ro, raw and enable
    //   14 interrupt clear, wo, a one clears
    //   18 modem set, a one asserts; reads back the dtr and rts pins
    //   1c modem clear, wo, a one deasserts
    //   20 modem status, ro, synchronised cts, dsr, dcd and ri
    // unmapped offsets are acked, read zero and ignore writes
    // selection codes 0 to 4 stand for one, two, four, six and seven eighths
    // fields that need lane 0 ignore writes without it

    // timing of one classic cycle:
    //   edge 1 sees the request, raises ack and latches read data
    //   edge 2 sees ack high; a write lands here and ack drops
    //   the master releases before it asks again
    // request decode; writes land on the edge that samples ack
    always_comb begin
        wval = WB_REQ.dat & lane_mask;
        wr_go = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && s_q.ack;
        rd_go = WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !s_q.ack;
    end

    // threshold events are crossings, not levels: a cleared transmit or
    // receive bit stays clear while the fifo sits past its threshold
    // a selection change that moves the threshold across the level
    // counts as a crossing, since the stored condition is compared each cycle

    // threshold conditions; tx fires when level falls to it, rx when it rises to it
    always_comb begin
        tx_cond_now = TX_FIFO_LEVEL <= thresh_level(s_q.tx_sel); // RULE_01
        rx_cond_now = RX_FIFO_LEVEL >= thresh_level(s_q.rx_sel); // RULE_01
        rx_has_room = 32'(RX_FIFO_LEVEL) < FIFO_DEPTH;
        modem_edge = modem_sync ^ s_q.modem_prev;
    end

    // interrupt sources:
    //   0 address match, 1 overrun, 2 break, 3 parity, 4 framing
    //   5 receive timeout, 6 transmit level, 7 receive level
    //   8 dsr, 9 dcd, 10 cts, 11 ri changes
    // a modem pin change reaches its status bit three edges later
    // hazard: events arriving while CE is low are not remembered

    // event sources; entering a condition sets, so a clear holds until it recurs
    always_comb begin
        irq_set = '0;
        irq_set[`UIFMC_IRQ_ADDR_MATCH] = RX_EVENTS.address_match; // RULE_07
        irq_set[`UIFMC_IRQ_OVERRUN] = RX_EVENTS.overrun;
        irq_set[`UIFMC_IRQ_BREAK] = RX_EVENTS.break_seen;
        irq_set[`UIFMC_IRQ_PARITY] = RX_EVENTS.parity_fault;
        irq_set[`UIFMC_IRQ_FRAMING] = RX_EVENTS.framing_fault;
        irq_set[`UIFMC_IRQ_RX_TIMEOUT] = RX_EVENTS.receive_timeout;
        irq_set[`UIFMC_IRQ_TRANSMIT] = tx_cond_now && !s_q.tx_cond;
        irq_set[`UIFMC_IRQ_RECEIVE] = rx_cond_now && !s_q.rx_cond;
        irq_set[`UIFMC_IRQ_DSR] = modem_edge[`UIFMC_MS_DSR];
        irq_set[`UIFMC_IRQ_DCD] = modem_edge[`UIFMC_MS_DCD];
        irq_set[`UIFMC_IRQ_CTS] = modem_edge[`UIFMC_MS_CTS];
        irq_set[`UIFMC_IRQ_RI] = modem_edge[`UIFMC_MS_RI];
        irq_clr = '0;
        if (wr_go && WB_REQ.adr == `UIFMC_OFF_IRQ_CLEAR) begin
            irq_clr = wval[`UIFMC_IRQ_COUNT-1:0]; // RULE_08
        end
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;

        // wishbone answer one cycle after the request, dropped the cycle after
        s_d.ack = WB_REQ.cyc && WB_REQ.stb && !s_q.ack;

        // status: a set in the same cycle as its clear wins
        s_d.irq_raw = (s_q.irq_raw & ~irq_clr) | irq_set; // RULE_08
        s_d.tx_cond = tx_cond_now;
        s_d.rx_cond = rx_cond_now;
        s_d.modem_prev = modem_sync;

        // register writes
        if (wr_go) begin
            if (WB_REQ.adr == `UIFMC_OFF_FIFO_LEVEL) begin
                if (WB_REQ.sel[0]) begin
                    s_d.tx_sel = legal_sel(WB_REQ.dat[`UIFMC_TX_SEL_LSB +: 3], s_q.tx_sel); // RULE_01
                    s_d.rx_sel = legal_sel(WB_REQ.dat[`UIFMC_RX_SEL_LSB +: 3], s_q.rx_sel); // RULE_01
                end
            end else if (WB_REQ.adr == `UIFMC_OFF_FLOW_CTRL) begin
                if (WB_REQ.sel[0]) begin
                    s_d.cts_gated_transmit_enable = WB_REQ.dat[`UIFMC_CTS_GATED_BIT]; // RULE_04
                    s_d.rts_driven_receive_enable = WB_REQ.dat[`UIFMC_RTS_DRIVEN_BIT]; // RULE_04
                end
            end else if (WB_REQ.adr == `UIFMC_OFF_IRQ_ENABLE) begin
                // per-byte merge so a narrow write touches only its lanes
                s_d.irq_en = (s_q.irq_en & ~lane_mask[`UIFMC_IRQ_COUNT-1:0])
                           | wval[`UIFMC_IRQ_COUNT-1:0]; // RULE_05
            end else if (WB_REQ.adr == `UIFMC_OFF_MODEM_SET) begin
                s_d.dtr_sw = s_q.dtr_sw | wval[`UIFMC_DTR_BIT]; // RULE_11
                s_d.rts_sw = s_q.rts_sw | wval[`UIFMC_RTS_BIT]; // RULE_11
            end else if (WB_REQ.adr == `UIFMC_OFF_MODEM_CLEAR) begin
                s_d.dtr_sw = s_q.dtr_sw & ~wval[`UIFMC_DTR_BIT]; // RULE_10
                s_d.rts_sw = s_q.rts_sw & ~wval[`UIFMC_RTS_BIT]; // RULE_10
            end
        end

        // register reads, captured on the edge that raises ack
        s_d.rdat = '0;
        if (rd_go) begin
            if (WB_REQ.adr == `UIFMC_OFF_FIFO_LEVEL) begin
                s_d.rdat[`UIFMC_TX_SEL_LSB +: 3] = s_q.tx_sel;
                s_d.rdat[`UIFMC_RX_SEL_LSB +: 3] = s_q.rx_sel;
            end else if (WB_REQ.adr == `UIFMC_OFF_FLOW_CTRL) begin
                // both zero reads back as no_hardware_handshake
                s_d.rdat[`UIFMC_CTS_GATED_BIT] = s_q.cts_gated_transmit_enable; // RULE_04
                s_d.rdat[`UIFMC_RTS_DRIVEN_BIT] = s_q.rts_driven_receive_enable; // RULE_04
            end else if (WB_REQ.adr == `UIFMC_OFF_IRQ_ENABLE) begin
                s_d.rdat[`UIFMC_IRQ_COUNT-1:0] = s_q.irq_en;
            end else if (WB_REQ.adr == `UIFMC_OFF_IRQ_RAW) begin
                s_d.rdat[`UIFMC_IRQ_COUNT-1:0] = s_q.irq_raw; // RULE_09
            end else if (WB_REQ.adr == `UIFMC_OFF_IRQ_MASKED) begin
                s_d.rdat[`UIFMC_IRQ_COUNT-1:0] = s_q.irq_raw & s_q.irq_en; // RULE_09
            end else if (WB_REQ.adr == `UIFMC_OFF_MODEM_SET) begin
                // the pins as driven, including hardware rts
                s_d.rdat[`UIFMC_DTR_BIT] = s_q.dtr_pin; // RULE_12
                s_d.rdat[`UIFMC_RTS_BIT] = s_q.rts_pin; // RULE_12
            end else if (WB_REQ.adr == `UIFMC_OFF_MODEM_STATUS) begin
                s_d.rdat[3:0] = modem_sync;
            end
            // clear registers, write-only ones and holes read as zero
        end

        // interrupt line from the registered status and mask
        s_d.irq = |(s_q.irq_raw & s_q.irq_en); // RULE_06 RULE_13

        // flow control trade-offs:
        //   cts is seen through the synchroniser, so a deasserted cts may
        //   still let the serializer start for up to three cycles; the far
        //   side must allow a character or so of slack
        //   hardware rts drops only when the fifo is completely full, so the
        //   far side must stop within the time of one character
        //   software rts and dtr keep their values while hardware drives rts
        // transmit gate; cts is the synchronised copy, two cycles behind the pin
        s_d.send_ok = !s_q.cts_gated_transmit_enable || modem_sync[`UIFMC_MS_CTS]; // RULE_02

        // rts from fifo room in hardware mode, else from software
        if (s_q.rts_driven_receive_enable) begin
            s_d.rts_pin = rx_has_room; // RULE_03
        end else begin
            s_d.rts_pin = s_q.rts_sw; // RULE_10 RULE_11
        end
        s_d.dtr_pin = s_q.dtr_sw;
    end

    // state register, frozen while CE is low
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.tx_sel <= uifmc_pkg::uifmc_thresh_type'(`UIFMC_RST_FIFO_SEL);
            s_q.rx_sel <= uifmc_pkg::uifmc_thresh_type'(`UIFMC_RST_FIFO_SEL);
            s_q.irq_en <= `UIFMC_RST_IRQ_ENABLE;
            {s_q.rts_driven_receive_enable, s_q.cts_gated_transmit_enable} <= `UIFMC_RST_FLOW;
            {s_q.rts_sw, s_q.dtr_sw} <= `UIFMC_RST_MODEM;
            s_q.send_ok <= 1'b1;
            // tx threshold state starts true and rx starts false, so reset with empty fifos raises no event
            s_q.tx_cond <= 1'b1;
            s_q.rx_cond <= 1'b0;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign WB_ACK = s_q.ack;
    assign WB_DAT = s_q.rdat;
    assign IRQ = s_q.irq;
    assign RTS = s_q.rts_pin;
    assign DTR = s_q.dtr_pin;
    assign TX_SEND_OK = s_q.send_ok;

endmodule

//--- verification/uifmc_far_modem.sv
// remote modem model: drives the four handshake status pins
`timescale 1ns/10ps
module uifmc_far_modem (
    // clock and wanted pin states from the bench
    input wire logic clk,
    input wire logic [3:0] want,
    // line side, high means asserted
    output uifmc_pkg::uifmc_modem_in_type pins
);
    logic [3:0] want_q = 4'h0;

    // pins move just after an edge, never mid-cycle
    always_ff @(posedge clk) begin
        want_q <= want;
    end
    assign pins = want_q;
endmodule

//--- verification/uifmc_sva.sv
// assertion checker for the uart irq/flow/modem block
`timescale 1ns/10ps
module uifmc_checker #(
    parameter int FIFO_DEPTH = 16,
    parameter int LEVEL_W = 5
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register bus
    input wire uifmc_pkg::uifmc_wb_req_type WB_REQ,
    input wire logic WB_ACK,
    input wire logic [31:0] WB_DAT,
    // datapath and pins
    input wire logic [LEVEL_W-1:0] RX_FIFO_LEVEL,
    input wire uifmc_pkg::uifmc_modem_in_type MODEM_IN,
    input wire logic TX_SEND_OK,
    input wire logic RTS,
    input wire logic DTR,
    input wire logic IRQ
);
    logic wr_ack;
    logic [1:0] flow_q;
    logic [11:0] en_q;
    logic [11:0] en_lanes;

    // mirrors of flow mode and enables, merged by byte lane as the block does
    assign wr_ack = WB_ACK && WB_REQ.we;
    assign en_lanes = {{4{WB_REQ.sel[1]}}, {8{WB_REQ.sel[0]}}};
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            flow_q <= 2'h0;
            en_q <= 12'h000;
        end else if (wr_ack && WB_REQ.sel[0] && WB_REQ.adr == 8'h04) begin
            flow_q <= WB_REQ.dat[1:0];
        end else if (wr_ack && WB_REQ.adr == 8'h08) begin
            en_q <= (en_q & ~en_lanes) | (WB_REQ.dat[11:0] & en_lanes);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // a write taking effect at a given offset
    sequence s_wr(logic [7:0] a);
        wr_ack && WB_REQ.adr == a;
    endsequence
    sequence s_dtr_on;
        s_wr(8'h18) ##0 (WB_REQ.dat[0] && WB_REQ.sel[0]);
    endsequence
    sequence s_dtr_off;
        s_wr(8'h1C) ##0 (WB_REQ.dat[0] && WB_REQ.sel[0]);
    endsequence

    property p_ack_once;
        WB_ACK |=> !WB_ACK;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_due;
        WB_REQ.cyc && WB_REQ.stb && !WB_ACK |=> WB_ACK;
    endproperty
    a_ack_due: assert property (p_ack_due) else $error("ack missing");
    property p_send_gate;
        !TX_SEND_OK |-> !$past(MODEM_IN.cts, 3);
    endproperty
    a_send_gate: assert property (p_send_gate) else $error("send held with cts up");
    property p_send_free;
        !flow_q[0] |=> TX_SEND_OK;
    endproperty
    a_send_free: assert property (p_send_free) else $error("send held without gating");
    property p_rts_room;
        flow_q[1] |=> RTS == ($past(RX_FIFO_LEVEL) < FIFO_DEPTH);
    endproperty
    a_rts_room: assert property (p_rts_room) else $error("rts not following room");
    property p_irq_masked;
        (en_q == 12'h000) [*3] |-> !IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
    property p_irq_fall;
        $fell(IRQ) |-> $past(wr_ack, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
    property p_dtr_on;
        s_dtr_on |-> ##[1:2] DTR;
    endproperty
    a_dtr_on: assert property (p_dtr_on) else $error("dtr not asserted");
    property p_dtr_off;
        s_dtr_off |-> ##[1:2] !DTR;
    endproperty
    a_dtr_off: assert property (p_dtr_off) else $error("dtr not released");
    property p_mc_read;
        WB_ACK && !WB_REQ.we && WB_REQ.adr == 8'h18 |-> WB_DAT[1:0] == {RTS, DTR};
    endproperty
    a_mc_read: assert property (p_mc_read) else $error("modem readback wrong");
endmodule

bind uifmc_top uifmc_checker #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W)) u_uifmc_checker (.CLK(CLK),
    .SYS_RST(SYS_RST), .WB_REQ(WB_REQ), .WB_ACK(WB_ACK), .WB_DAT(WB_DAT), .RX_FIFO_LEVEL(RX_FIFO_LEVEL),
    .MODEM_IN(MODEM_IN), .TX_SEND_OK(TX_SEND_OK), .RTS(RTS), .DTR(DTR), .IRQ(IRQ));

//--- verification/uifmc_tb_top.sv
// self-checking bench for the uart irq/flow/modem block
`timescale 1ns/10ps
module uifmc_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [4:0] tx_lv = 5'h00;
    logic [4:0] rx_lv = 5'h00;
    logic [3:0] want = 4'h0;
    uifmc_pkg::uifmc_wb_req_type req = '0;
    uifmc_pkg::uifmc_rx_event_type ev = '0;
    uifmc_pkg::uifmc_modem_in_type pins;
    logic ack, rts, dtr, irq, send_ok;
    logic [31:0] dat;
    int err_total = 0;
    int n_compared = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    uifmc_top u_uifmc_top (.CLK(clk), .SYS_RST(rst), .CE(ce), .WB_REQ(req), .WB_ACK(ack), .WB_DAT(dat),
        .TX_FIFO_LEVEL(tx_lv), .RX_FIFO_LEVEL(rx_lv), .RX_EVENTS(ev), .MODEM_IN(pins),
        .TX_SEND_OK(send_ok), .RTS(rts), .DTR(dtr), .IRQ(irq));
    uifmc_far_modem u_uifmc_far_modem (.clk(clk), .want(want), .pins(pins));

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask

    // one classic cycle; entered just after an edge, leaves one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, w, a, s, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            complete_run();
        end
        r = dat;
        req <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, 4'hF, r);
    endtask

    // write with an explicit byte-lane select
    task automatic wrl(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        wb(1'b1, a, d, s, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, 4'hF, r);
        chk(e, r);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values
        rdc(8'h00, 32'h22);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h18, 32'h0);
        // every threshold code; reserved codes leave the fields alone
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, {25'h0, i[2:0], 1'b0, i[2:0]});
            rdc(8'h00, {25'h0, i[2:0], 1'b0, i[2:0]});
        end
        wr(8'h00, 32'h57);
        rdc(8'h00, 32'h44);
        wr(8'h00, 32'h22);
        // all twelve sources: line events, fifo crossings at 8, modem pin changes
        wr(8'h14, 32'hFFF);
        wr(8'h08, 32'h82);
        ev <= '1;
        tx_lv <= 5'h10;
        want <= 4'hF;
        @(posedge clk);
        ev <= '0;
        tx_lv <= 5'h08;
        rx_lv <= 5'h08;
        repeat (6) @(posedge clk);
        rdc(8'h0C, 32'hFFF);
        rdc(8'h10, 32'h82);
        chk(32'h1, {31'h0, irq});
        wr(8'h14, 32'h2);
        rdc(8'h0C, 32'hFFD);
        chk(32'h1, {31'h0, irq});
        wr(8'h14, 32'h80);
        @(posedge clk);
        chk(32'h0, {31'h0, irq});
        rdc(8'h10, 32'h0);
        rdc(8'h14, 32'h0);
        // modem outputs set together, then cleared and set one at a time
        wr(8'h18, 32'h3);
        rdc(8'h18, 32'h3);
        wr(8'h1C, 32'h1);
        rdc(8'h18, 32'h2);
        chk(32'h2, {30'h0, rts, dtr});
        wr(8'h18, 32'h1);
        rdc(8'h18, 32'h3);
        rdc(8'h20, 32'hF);
        // cts gating and rts from receive room, full fifo then one free slot
        wr(8'h04, 32'h3);
        rdc(8'h04, 32'h3);
        want <= 4'hE;
        rx_lv <= 5'h10;
        repeat (5) @(posedge clk);
        chk(32'h0, {30'h0, send_ok, rts});
        want <= 4'hF;
        rx_lv <= 5'h0F;
        repeat (5) @(posedge clk);
        chk(32'h3, {30'h0, send_ok, rts});
        wr(8'h04, 32'h1);
        rdc(8'h04, 32'h1);
        // other threshold codes: transmit at one eighth, receive at seven eighths
        wr(8'h00, 32'h40);
        wr(8'h14, 32'hFFF);
        rx_lv <= 5'h0D;
        tx_lv <= 5'h03;
        @(posedge clk);
        rx_lv <= 5'h0E;
        tx_lv <= 5'h02;
        repeat (2) @(posedge clk);
        rdc(8'h0C, 32'hC0);
        // enable, then mask again while status stays set
        wr(8'h08, 32'hC0);
        rdc(8'h10, 32'hC0);
        chk(32'h1, {31'h0, irq});
        wr(8'h08, 32'h0);
        @(posedge clk);
        chk(32'h0, {31'h0, irq});
        rdc(8'h10, 32'h0);
        // a narrow write touches only its own byte lane
        wrl(8'h08, 32'hFFF, 4'h2);
        rdc(8'h08, 32'hF00);
        chk(32'h0, {31'h0, irq});
        // events while the clock enable is low leave no trace
        ce <= 1'b0;
        ev <= '1;
        @(posedge clk);
        ev <= '0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        rdc(8'h0C, 32'hC0);
        rdc(8'h40, 32'h0);
        complete_run();
    end
endmodule
